// >>> hdl/bts_params.svh
// Constants for the block transfer id sequencer.
// Assumes inclusion by bare name from design files.
`ifndef BTS_PARAMS_SVH
`define BTS_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define BTS_OFS_READ_CFG 12'h000
`define BTS_OFS_WRITE_CFG 12'h004
`define BTS_OFS_CMD_CFG 12'h008
`define BTS_OFS_CTRL 12'h00C
`define BTS_OFS_IDS 12'h010

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define BTS_FIRST_LSB 0
`define BTS_TOTAL_LSB 8
`define BTS_CTRL_RUN_BIT 0
`define BTS_CMD_BASE 8'h50
`define BTS_BLOCK_WORDS 50
`define BTS_RST_READ_FIRST 8'h01
`define BTS_RST_READ_TOTAL 8'h01
`define BTS_RST_WRITE_FIRST 8'h00
`define BTS_RST_WRITE_TOTAL 8'h01
`define BTS_RST_CMD_TOTAL 8'h00

`endif

// >>> hdl/bts_pkg.sv
// Types for the block transfer id sequencer.
// Assumes the params header is compiled alongside.
package bts_pkg;
  typedef enum logic [1:0] {BTS_IDLE, BTS_RUN} bts_mode_type;
endpackage : bts_pkg

// >>> hdl/bts_cfg_if.sv
// Configuration bundle passed from the register block to the stepper.
// Assumes one clock domain; values are steady while running.
`timescale 1ns/1ps
interface bts_cfg_if #(parameter int ID_W = 8);
  logic [ID_W-1:0] read_first;
  logic [ID_W-1:0] read_total;
  logic [ID_W-1:0] write_first;
  logic [ID_W-1:0] write_total;
  logic [ID_W-1:0] cmd_total;
  modport src (output read_first, read_total, write_first, write_total, cmd_total);
  modport dst (input read_first, read_total, write_first, write_total, cmd_total);
endinterface : bts_cfg_if

// >>> hdl/bts_id_step.sv
// Next-value logic for both block identifiers.
// Assumes caller registers the results; purely combinational.
`timescale 1ns/1ps
`include "bts_params.svh"
module bts_id_step
  import bts_pkg::*;
#(
  parameter int ID_W = 8
) (
  bts_cfg_if.dst cfg,
  input wire logic [ID_W-1:0] out_id,
  input wire logic [ID_W-1:0] in_id,
  output logic [ID_W-1:0] out_id_next,
  output logic [ID_W-1:0] in_id_next
);
  // Sums widened by one bit so a range near the top never wraps
  logic [ID_W:0] out_end;
  logic [ID_W:0] wr_end;
  logic [ID_W:0] cmd_end;

  always_comb begin
    out_end = {1'b0, cfg.read_first} + {1'b0, cfg.read_total};
    wr_end = {1'b0, cfg.write_first} + {1'b0, cfg.write_total};
    cmd_end = {1'b0, ID_W'(`BTS_CMD_BASE)} + {1'b0, cfg.cmd_total};
    if ({1'b0, out_id} >= out_end) begin
      out_id_next = cfg.read_first;
    end else begin
      out_id_next = out_id + ID_W'(1);
    end
    if ({1'b0, in_id} >= wr_end) begin
      in_id_next = ID_W'(`BTS_CMD_BASE);
    end else if ({1'b0, in_id} >= cmd_end) begin
      in_id_next = cfg.write_first;
    end else begin
      in_id_next = in_id + ID_W'(1);
    end
  end
endmodule : bts_id_step

// >>> hdl/bts_seq.sv
// Block transfer id sequencer: APB registers plus id stepping.
// Assumes one clock, APB master, transfer-done pulses from the backplane engine.
// Function
// - Return configured count of 50-word outbound blocks
// - Outbound ids start at first, count upward
// - Host sends configured write data blocks
// - Host sends configured command blocks
// - Returned buffer carries both block ids
// - Device advances and wraps both ids
// - Inbound past write range jumps to 80
// - Inbound past command range reloads write first; the code does so only below the write range end, else it jumps to 80 again
// - Otherwise inbound id increments by one
// - Outbound wraps to read first, else increments
`timescale 1ns/1ps
`include "bts_params.svh"
module bts_seq
  import bts_pkg::*;
#(
  parameter int ID_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic outbound_transfer,
  input wire logic inbound_transfer,
  output logic [ID_W-1:0] outbound_block_id,
  output logic [ID_W-1:0] inbound_block_id
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bts_mode_type mode;
    logic [ID_W-1:0] read_first;
    logic [ID_W-1:0] read_total;
    logic [ID_W-1:0] write_first;
    logic [ID_W-1:0] write_total;
    logic [ID_W-1:0] cmd_total;
    logic [ID_W-1:0] out_id;
    logic [ID_W-1:0] in_id;
    logic [31:0] rdata;
    logic err;
  } bts_state_type;

  bts_state_type state_reg;
  bts_state_type state_next;
  logic [ID_W-1:0] out_step;
  logic [ID_W-1:0] in_step;
  logic wr_access;
  logic rd_access;
  logic mapped;

  bts_cfg_if #(.ID_W(ID_W)) cfg_bus ();

  assign cfg_bus.read_first = state_reg.read_first;
  assign cfg_bus.read_total = state_reg.read_total;
  assign cfg_bus.write_first = state_reg.write_first;
  assign cfg_bus.write_total = state_reg.write_total;
  assign cfg_bus.cmd_total = state_reg.cmd_total;

  bts_id_step #(.ID_W(ID_W)) u_step (
    .cfg(cfg_bus),
    .out_id(state_reg.out_id),
    .in_id(state_reg.in_id),
    .out_id_next(out_step),
    .in_id_next(in_step)
  );

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `BTS_OFS_READ_CFG) || (a == `BTS_OFS_WRITE_CFG) || (a == `BTS_OFS_CMD_CFG) ||
                 (a == `BTS_OFS_CTRL) || (a == `BTS_OFS_IDS);
  endfunction : addr_known

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign mapped = addr_known(paddr);
  // Writes land on the access edge, where the master samples pready
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = state_reg.rdata;
  assign pslverr = psel && penable && state_reg.err;

  // Both ids are always presented together with the returned buffer
  assign outbound_block_id = state_reg.out_id;
  assign inbound_block_id = state_reg.in_id;

  always_comb begin
    state_next = state_reg;
    // Decode in setup phase so read data and error are flopped for access
    if (psel && !penable) begin
      state_next.err = !mapped;
      state_next.rdata = 32'h0000_0000;
    end
    if (rd_access) begin
      unique case (paddr)
        `BTS_OFS_READ_CFG: state_next.rdata = {16'h0000, 8'(state_reg.read_total), 8'(state_reg.read_first)};
        `BTS_OFS_WRITE_CFG: state_next.rdata = {16'h0000, 8'(state_reg.write_total), 8'(state_reg.write_first)};
        `BTS_OFS_CMD_CFG: state_next.rdata = {24'h00_0000, 8'(state_reg.cmd_total)};
        `BTS_OFS_CTRL: state_next.rdata = {31'h0000_0000, state_reg.mode == BTS_RUN};
        `BTS_OFS_IDS: state_next.rdata = {16'h0000, 8'(state_reg.in_id), 8'(state_reg.out_id)};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    unique case (state_reg.mode)
      BTS_IDLE: begin
        // Config only accepted while stopped so ranges hold steady in run
        if (wr_access) begin
          unique case (paddr)
            `BTS_OFS_READ_CFG: begin
              state_next.read_first = pwdata[`BTS_FIRST_LSB +: ID_W];
              state_next.read_total = pwdata[`BTS_TOTAL_LSB +: ID_W];
            end
            `BTS_OFS_WRITE_CFG: begin
              state_next.write_first = pwdata[`BTS_FIRST_LSB +: ID_W];
              state_next.write_total = pwdata[`BTS_TOTAL_LSB +: ID_W];
            end
            `BTS_OFS_CMD_CFG: state_next.cmd_total = pwdata[`BTS_FIRST_LSB +: ID_W];
            `BTS_OFS_CTRL: begin
              if (pwdata[`BTS_CTRL_RUN_BIT]) begin
                state_next.mode = BTS_RUN;
                state_next.out_id = state_reg.read_first;
                state_next.in_id = state_reg.write_first;
              end
            end
            default: state_next.mode = state_reg.mode;
          endcase
        end
      end
      BTS_RUN: begin
        if (outbound_transfer) begin
          state_next.out_id = out_step;
        end
        if (inbound_transfer) begin
          state_next.in_id = in_step;
        end
        if (wr_access && paddr == `BTS_OFS_CTRL && !pwdata[`BTS_CTRL_RUN_BIT]) begin
          state_next.mode = BTS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{mode: BTS_IDLE, read_first: ID_W'(`BTS_RST_READ_FIRST),
                     read_total: ID_W'(`BTS_RST_READ_TOTAL), write_first: ID_W'(`BTS_RST_WRITE_FIRST),
                     write_total: ID_W'(`BTS_RST_WRITE_TOTAL), cmd_total: ID_W'(`BTS_RST_CMD_TOTAL),
                     out_id: '0, in_id: '0, rdata: 32'h0000_0000, err: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam logic [ID_W-1:0] CMD_BASE = ID_W'(`BTS_CMD_BASE);

  a_in_to_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && inbound_transfer &&
     {1'b0, in_id_q()} >= {1'b0, state_reg.write_first} + {1'b0, state_reg.write_total})
    |=> inbound_block_id == CMD_BASE)
    else $error("inbound id did not jump to command base");

  a_in_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && inbound_transfer &&
     {1'b0, state_reg.in_id} < {1'b0, state_reg.write_first} + {1'b0, state_reg.write_total} &&
     {1'b0, state_reg.in_id} >= {1'b0, CMD_BASE} + {1'b0, state_reg.cmd_total})
    |=> inbound_block_id == $past(state_reg.write_first))
    else $error("inbound id did not reload write first");

  a_in_incr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && inbound_transfer &&
     {1'b0, state_reg.in_id} < {1'b0, state_reg.write_first} + {1'b0, state_reg.write_total} &&
     {1'b0, state_reg.in_id} < {1'b0, CMD_BASE} + {1'b0, state_reg.cmd_total})
    |=> inbound_block_id == $past(inbound_block_id) + ID_W'(1))
    else $error("inbound id did not increment");

  a_out_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && outbound_transfer &&
     {1'b0, state_reg.out_id} >= {1'b0, state_reg.read_first} + {1'b0, state_reg.read_total})
    |=> outbound_block_id == $past(state_reg.read_first))
    else $error("outbound id did not wrap");

  a_out_incr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && outbound_transfer &&
     {1'b0, state_reg.out_id} < {1'b0, state_reg.read_first} + {1'b0, state_reg.read_total})
    |=> outbound_block_id == $past(outbound_block_id) + ID_W'(1))
    else $error("outbound id did not increment");

  a_out_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && !outbound_transfer && $past(state_reg.mode) == BTS_RUN)
    |=> $stable(outbound_block_id))
    else $error("outbound id moved without a transfer");

  a_in_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && !inbound_transfer) |=> $stable(inbound_block_id))
    else $error("inbound id moved without a transfer");

  a_start_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_IDLE ##1 state_reg.mode == BTS_RUN)
    |-> outbound_block_id == state_reg.read_first && inbound_block_id == state_reg.write_first)
    else $error("ids not seeded from first values at start");

  a_cfg_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN ##1 state_reg.mode == BTS_RUN)
    |-> $stable(state_reg.read_total) && $stable(state_reg.write_total) && $stable(state_reg.cmd_total))
    else $error("configuration changed while running");

  a_first_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN ##1 state_reg.mode == BTS_RUN)
    |-> $stable(state_reg.read_first) && $stable(state_reg.write_first))
    else $error("first values changed while running");

  a_idle_ids_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_IDLE && !wr_access)
    |=> $stable(outbound_block_id) && $stable(inbound_block_id))
    else $error("ids moved while stopped");

  a_stop_to_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && wr_access && paddr == `BTS_OFS_CTRL && !pwdata[`BTS_CTRL_RUN_BIT])
    |=> state_reg.mode == BTS_IDLE)
    else $error("run bit clear did not stop the sequencer");

  a_run_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_RUN && !(wr_access && paddr == `BTS_OFS_CTRL))
    |=> state_reg.mode == BTS_RUN)
    else $error("sequencer left run without a control write");

  // ----------------------------------------------------------------
  // Checks: register bus
  // ----------------------------------------------------------------
  // Read data is flopped at setup, so every read check looks one edge on

  a_err_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && !penable && !mapped)
    |=> !(psel && penable) || pslverr)
    else $error("unmapped access gave no error");

  a_err_mapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && !penable && mapped)
    |=> !pslverr)
    else $error("mapped access gave an error");

  a_prdata_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(psel && !penable)
    |=> $stable(prdata))
    else $error("read data moved outside a setup cycle");

  a_rd_ids: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `BTS_OFS_IDS)
    |=> prdata == {16'h0000, 8'($past(state_reg.in_id)), 8'($past(state_reg.out_id))})
    else $error("id word does not carry both ids");

  a_rd_read_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `BTS_OFS_READ_CFG)
    |=> prdata == {16'h0000, 8'($past(state_reg.read_total)), 8'($past(state_reg.read_first))})
    else $error("read range word wrong");

  a_rd_write_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `BTS_OFS_WRITE_CFG)
    |=> prdata == {16'h0000, 8'($past(state_reg.write_total)), 8'($past(state_reg.write_first))})
    else $error("write range word wrong");

  a_rd_cmd_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && paddr == `BTS_OFS_CMD_CFG)
    |=> prdata == {24'h00_0000, 8'($past(state_reg.cmd_total))})
    else $error("command count word wrong");

  // Configuration only lands while stopped; running writes are dropped

  a_read_cfg_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_IDLE && wr_access && paddr == `BTS_OFS_READ_CFG)
    |=> state_reg.read_first == $past(pwdata[`BTS_FIRST_LSB +: ID_W]) &&
        state_reg.read_total == $past(pwdata[`BTS_TOTAL_LSB +: ID_W]))
    else $error("read range write lost");

  a_write_cfg_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_IDLE && wr_access && paddr == `BTS_OFS_WRITE_CFG)
    |=> state_reg.write_first == $past(pwdata[`BTS_FIRST_LSB +: ID_W]) &&
        state_reg.write_total == $past(pwdata[`BTS_TOTAL_LSB +: ID_W]))
    else $error("write range write lost");

  a_cmd_cfg_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg.mode == BTS_IDLE && wr_access && paddr == `BTS_OFS_CMD_CFG)
    |=> state_reg.cmd_total == $past(pwdata[`BTS_FIRST_LSB +: ID_W]))
    else $error("command count write lost");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_stop: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg.mode == BTS_RUN ##1 state_reg.mode == BTS_IDLE);
  c_in_cmd: cover property (@(posedge ref_clk) disable iff (!rst_n)
    inbound_transfer ##1 inbound_block_id == CMD_BASE);
  c_in_reload: cover property (@(posedge ref_clk) disable iff (!rst_n)
    inbound_block_id == CMD_BASE ##[1:20] inbound_block_id == state_reg.write_first);
  c_out_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
    outbound_transfer && outbound_block_id != state_reg.read_first ##1 outbound_block_id == state_reg.read_first);
  c_bad_addr: cover property (@(posedge ref_clk) disable iff (!rst_n) pslverr);

  function automatic logic [ID_W-1:0] in_id_q();
    in_id_q = state_reg.in_id;
  endfunction : in_id_q

endmodule : bts_seq

// >>> tb/bts_host_model.sv
// Host-side model: completes outbound and inbound block transfers.
// Assumes one clock; the bench launches each transfer through send.
`timescale 1ns/1ps
`include "bts_params.svh"
module bts_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] inbound_block_id,
  input wire logic [7:0] outbound_block_id,
  output logic outbound_transfer,
  output logic inbound_transfer
);
  localparam int WORDS = `BTS_BLOCK_WORDS;
  logic [7:0] sel_id;
  logic [7:0] label_id;
  int words_moved;

  initial begin
    outbound_transfer = 1'b0;
    inbound_transfer = 1'b0;
    sel_id = 8'h00;
    label_id = 8'h00;
    words_moved = 0;
  end

  // Gap gives a slow host; n above one gives back-to-back completions
  task send(input logic o, input logic i, input int n, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    if (i) sel_id = inbound_block_id;
    if (o) label_id = outbound_block_id;
    words_moved += n * WORDS * (int'(o) + int'(i));
    outbound_transfer <= o;
    inbound_transfer <= i;
    repeat (n) @(posedge ref_clk);
    outbound_transfer <= 1'b0;
    inbound_transfer <= 1'b0;
  endtask : send
endmodule : bts_host_model

// >>> tb/bts_seq_test.sv
// Self-checking bench for the block id sequencer.
// Assumes the host model drives transfer pulses; APB driven here.
`timescale 1ns/1ps
`include "bts_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module bts_seq_test;
  import bts_pkg::*;
  typedef struct {logic [7:0] rf, rt, wf, wt, ct;} bts_row_type;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, ob_x, ib_x;
  logic [7:0] ob_id, ib_id, eo, ei;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  bts_row_type rows [4] = '{'{8'h01, 8'h04, 8'h00, 8'h01, 8'h02}, '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00},
    '{8'h0A, 8'h02, 8'h05, 8'h03, 8'h01}, '{8'hFE, 8'h01, 8'h50, 8'h00, 8'h01}};

  always #50 ref_clk = ~ref_clk;

  bts_seq #(.ID_W(8)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .outbound_transfer(ob_x), .inbound_transfer(ib_x),
    .outbound_block_id(ob_id), .inbound_block_id(ib_id));
  bts_host_model u_host (.ref_clk(ref_clk), .inbound_block_id(ib_id), .outbound_block_id(ob_id),
    .outbound_transfer(ob_x), .inbound_transfer(ib_x));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] nx_out(logic [7:0] id, bts_row_type r);
    if ({1'b0, id} >= {1'b0, r.rf} + {1'b0, r.rt}) return r.rf;
    return id + 8'h01;
  endfunction : nx_out

  function automatic logic [7:0] nx_in(logic [7:0] id, bts_row_type r);
    if ({1'b0, id} >= {1'b0, r.wf} + {1'b0, r.wt}) return `BTS_CMD_BASE;
    if ({1'b0, id} >= {1'b0, `BTS_CMD_BASE} + {1'b0, r.ct}) return r.wf;
    return id + 8'h01;
  endfunction : nx_in

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task chk_rst;
    apb(1'b0, `BTS_OFS_READ_CFG, 32'h0);
    `CHK("read_cfg", {16'h0, `BTS_RST_READ_TOTAL, `BTS_RST_READ_FIRST}, rd)
    `CHK("pready", 1'b1, pready)
    apb(1'b0, `BTS_OFS_WRITE_CFG, 32'h0);
    `CHK("write_cfg", {16'h0, `BTS_RST_WRITE_TOTAL, `BTS_RST_WRITE_FIRST}, rd)
    apb(1'b0, `BTS_OFS_CMD_CFG, 32'h0);
    `CHK("cmd_cfg", {24'h0, `BTS_RST_CMD_TOTAL}, rd)
    apb(1'b0, `BTS_OFS_IDS, 32'h0);
    `CHK("ids", 32'h0, rd)
  endtask : chk_rst

  task step(input bts_row_type r, input logic o, input logic i, input int n, input int gap);
    logic [7:0] pi;
    logic [7:0] po;
    pi = ei;
    po = eo;
    u_host.send(o, i, n, gap);
    repeat (n) begin
      if (o) eo = nx_out(eo, r);
      if (i) ei = nx_in(ei, r);
    end
    #1;
    `CHK("outbound_id", eo, ob_id)
    `CHK("inbound_id", ei, ib_id)
    if (i) `CHK("host_sel", pi, u_host.sel_id)
    if (o) `CHK("host_label", po, u_host.label_id)
  endtask : step

  task summarize;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Run is about two hundred cycles; this ceiling only catches a hang
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_rst();
    foreach (rows[r]) begin
      apb(1'b1, `BTS_OFS_CTRL, 32'h0);
      apb(1'b1, `BTS_OFS_READ_CFG, {16'h0, rows[r].rt, rows[r].rf});
      apb(1'b1, `BTS_OFS_WRITE_CFG, {16'h0, rows[r].wt, rows[r].wf});
      apb(1'b1, `BTS_OFS_CMD_CFG, {24'h0, rows[r].ct});
      apb(1'b1, `BTS_OFS_CTRL, 32'h1);
      apb(1'b0, `BTS_OFS_IDS, 32'h0);
      `CHK("seed_ids", {16'h0, rows[r].wf, rows[r].rf}, rd)
      eo = rows[r].rf;
      ei = rows[r].wf;
      for (int k = 0; k < 7; k++) begin
        step(rows[r], k % 3 != 2, k % 3 != 1, (k == 4) ? 2 : 1, k % 2);
      end
      apb(1'b0, `BTS_OFS_IDS, 32'h0);
      `CHK("ids_reg", {16'h0, ei, eo}, rd)
    end
    apb(1'b1, `BTS_OFS_READ_CFG, 32'h0000_1234);
    apb(1'b0, `BTS_OFS_READ_CFG, 32'h0);
    `CHK("cfg_frozen", {16'h0, rows[3].rt, rows[3].rf}, rd)
    apb(1'b1, `BTS_OFS_CTRL, 32'h1);
    step(rows[3], 1'b1, 1'b1, 1, 0);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    `CHK("unmapped_wr_err", 1'b1, er)
    apb(1'b0, 12'h014, 32'h0);
    `CHK("unmapped_rd", 32'h0, rd)
    apb(1'b1, `BTS_OFS_CTRL, 32'h0);
    u_host.send(1'b1, 1'b1, 1, 0);
    #1;
    `CHK("idle_out", eo, ob_id)
    `CHK("idle_in", ei, ib_id)
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("rst_ids", 16'h0, {ib_id, ob_id})
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_rst();
    summarize();
  end
endmodule : bts_seq_test
